// ==== logic/bcc_map.svh ====
// bridge command/config registers: offsets, masks, reset values
// assumes byte addressing of configuration space, dword aligned access
//
// Functional notes
// - I/O space enable low: ignore primary I/O requests in the I/O window.
// - Memory enable low: ignore primary memory or prefetch window requests.
// - Forwarding off: upstream memory, I/O, MSI writes are unsupported.
// - Forwarding off: upstream non-posted memory/I/O requests complete as unsupported.
// - Forwarding enable never affects completions or non memory/I/O/MSI requests.
// - Poison log enable decides logging into master poison detected flag.
// - Own fatal/non-fatal errors sent if error report or device enable set.
// - Error report enable gates forwarded secondary fatal/non-fatal messages.
// - Secondary correctable error messages are always forwarded upstream.
// - Legacy interrupt disable deasserts the bridge's own interrupt output.
// - Legacy interrupt disable never affects forwarded secondary interrupts.
// - Command bits 3,4,5,7,9 and 15:11 are read-only zero.
// - Read-only 16-bit vendor identifier at offset 0x000.
// - Read-only 16-bit device identifier at offset 0x002.
// - Writable command bits reset to zero.
// - Poisoned downstream cpl or forwarded upstream request sets flag; write 1 clears.
// - System error flag set on own fatal/non-fatal message if report enabled.
`ifndef BCC_MAP_SVH
`define BCC_MAP_SVH

// byte addresses of dwords and 16-bit fields
`define BCC_OFF_ID        12'h000
`define BCC_OFF_CMD       12'h004
`define BCC_VENDOR_OFF    12'h000
`define BCC_DEVICE_OFF    12'h002
`define BCC_CMD_OFF       12'h004
`define BCC_STS_OFF       12'h006

// command field positions
`define BCC_CMD_IO        0
`define BCC_CMD_MEM       1
`define BCC_CMD_FWD       2
`define BCC_CMD_POISON    6
`define BCC_CMD_ERR       8
`define BCC_CMD_IRQD      10
`define BCC_CMD_WMASK     16'h0547
`define BCC_CMD_RESET     16'h0000

// status field positions
`define BCC_STS_POISON    8
`define BCC_STS_SYSERR    14
`define BCC_STS_RESET     16'h0000

`define BCC_ZERO32        32'h0000_0000

`endif

// ==== logic/bcc_pkg.sv ====
// bridge command/config registers: shared types
// assumes nothing beyond the map header
package bcc_pkg;
  // kind of a transaction layer packet seen at the bridge
  typedef enum logic [2:0] {
    KIND_MEM, KIND_IO, KIND_MSI, KIND_MSG, KIND_CPL, KIND_CFG
  } bcc_kind_e;
  // severity of an error message
  typedef enum logic [1:0] {SEV_CORR, SEV_NONFATAL, SEV_FATAL} bcc_sev_e;
endpackage

// ==== logic/bcc_cfg_port.sv ====
// configuration access decode: hit, byte write enables, one-cycle ack
// assumes requests come from link logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "bcc_map.svh"
module bcc_cfg_port (
  // clock and control
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // request
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [11:0] addr,
  input  wire logic [3:0]  be,
  // decode
  output logic             hit_id,
  output logic             hit_cmd,
  output logic [3:0]       wr_be,
  output logic             ack
);
  logic next_ack;

  function automatic logic dw_hit(input logic [11:0] a, input logic [11:0] o);
    dw_hit = (a[11:2] == o[11:2]);
  endfunction

  always_comb begin
    hit_id   = req && dw_hit(addr, `BCC_OFF_ID);
    hit_cmd  = req && dw_hit(addr, `BCC_OFF_CMD);
    wr_be    = (req && we && hit_cmd && !ack) ? be : 4'h0;
    next_ack = req && !ack;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ack <= 1'b0;
    end else if (ce) begin
      ack <= next_ack;
    end
  end
endmodule
`default_nettype wire

// ==== logic/bcc_fwd_gate.sv ====
// request gating by the command enables, purely combinational
// assumes window hits are computed by the caller's address decode
`timescale 1ns/1ps
`default_nettype none
module bcc_fwd_gate
  import bcc_pkg::*;
(
  // enables
  input  wire logic      io_space_enable,
  input  wire logic      memory_space_enable,
  input  wire logic      request_forwarding_enable,
  // primary side request
  input  wire logic      pri_valid,
  input  wire bcc_pkg::bcc_kind_e pri_kind,
  input  wire logic      in_io_win,
  input  wire logic      in_mem_win,
  input  wire logic      in_pmem_win,
  // upstream request
  input  wire logic      up_valid,
  input  wire bcc_pkg::bcc_kind_e up_kind,
  input  wire logic      up_nonposted,
  // decisions
  output logic           pri_claim,
  output logic           up_fwd,
  output logic           up_ur,
  output logic           up_ur_cpl
);
  function automatic logic gated(input bcc_kind_e k);
    gated = (k == KIND_MEM) || (k == KIND_IO) || (k == KIND_MSI);
  endfunction

  always_comb begin
    pri_claim = pri_valid &&
      ((io_space_enable && in_io_win && pri_kind == KIND_IO) ||
       (memory_space_enable && (in_mem_win || in_pmem_win) &&
        pri_kind == KIND_MEM));
    up_ur     = up_valid && gated(up_kind) &&
                !request_forwarding_enable;
    up_fwd    = up_valid && !up_ur;
    up_ur_cpl = up_ur && up_nonposted;
  end
endmodule
`default_nettype wire

// ==== logic/bcc_regs.sv ====
// bridge command/config registers, top: identity, command, two status flags
// assumes all inputs come from the port's link logic on CLOCK
`timescale 1ns/1ps
`default_nettype none
`include "bcc_map.svh"
module bcc_regs #(
  parameter logic [15:0] VENDOR_ID = 16'hA5A5, // arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h5A01  // arbitrary value
) (
  // clock, reset, enable
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        CE,
  // configuration access
  input  wire logic        CFG_REQ,
  input  wire logic        CFG_WE,
  input  wire logic [11:0] CFG_ADDR,
  input  wire logic [3:0]  CFG_BE,
  input  wire logic [31:0] CFG_WDATA,
  output logic [31:0]      CFG_RDATA,
  output logic             CFG_ACK,
  // primary side requests
  input  wire logic        PRI_VALID,
  input  wire bcc_pkg::bcc_kind_e PRI_KIND,
  input  wire logic        PRI_IN_IO_WIN,
  input  wire logic        PRI_IN_MEM_WIN,
  input  wire logic        PRI_IN_PMEM_WIN,
  output logic             PRI_CLAIM,
  // upstream requests
  input  wire logic        UP_VALID,
  input  wire bcc_pkg::bcc_kind_e UP_KIND,
  input  wire logic        UP_NONPOSTED,
  input  wire logic        UP_POISONED,
  output logic             UP_FWD,
  output logic             UP_UR,
  output logic             UP_UR_CPL,
  // downstream completions
  input  wire logic        DN_CPL_VALID,
  input  wire logic        DN_CPL_POISONED,
  // secondary error messages
  input  wire logic        SEC_ERR_VALID,
  input  wire bcc_pkg::bcc_sev_e SEC_ERR_SEV,
  output logic             PRI_ERR_FWD,
  output bcc_pkg::bcc_sev_e PRI_ERR_SEV,
  // own errors
  input  wire logic        OWN_ERR_NONFATAL,
  input  wire logic        OWN_ERR_FATAL,
  input  wire logic        DEV_NONFATAL_EN,
  input  wire logic        DEV_FATAL_EN,
  output logic             ERR_MSG_SEND,
  output logic             ERR_MSG_FATAL,
  // legacy interrupts
  input  wire logic        OWN_IRQ,
  input  wire logic        SEC_IRQ,
  output logic             OWN_IRQ_OUT,
  output logic             FWD_IRQ_OUT,
  // command and flag view
  output logic [15:0]      COMMAND,
  output logic             MASTER_POISON_DETECTED,
  output logic             SIGNALED_SYSTEM_ERROR
);
  import bcc_pkg::*;

  logic [15:0] pci_command;
  logic [15:0] next_pci_command;
  logic        master_poison_detected;
  logic        next_master_poison_detected;
  logic        sys_err;
  logic        next_sys_err;
  logic [31:0] next_rdata;
  logic        hit_id;
  logic        hit_cmd;
  logic [3:0]  wr_be;
  logic        io_space_enable;
  logic        memory_space_enable;
  logic        request_forwarding_enable;
  logic        poison_log_enable;
  logic        error_report_enable;
  logic        legacy_irq_disable;
  logic        poison_event;
  logic        send_nf;
  logic        send_f;
  logic        next_err_send;
  logic        next_err_fatal;
  logic        next_fwd;
  bcc_sev_e    next_fwd_sev;
  logic        next_own_irq;
  logic        next_fwd_irq;
  logic [15:0] wdata_cmd;
  logic [15:0] wdata_sts;

  // access decode
  bcc_cfg_port u_port (
    .clk    (CLOCK),
    .srst   (SRST),
    .ce     (CE),
    .req    (CFG_REQ),
    .we     (CFG_WE),
    .addr   (CFG_ADDR),
    .be     (CFG_BE),
    .hit_id (hit_id),
    .hit_cmd(hit_cmd),
    .wr_be  (wr_be),
    .ack    (CFG_ACK)
  );

  assign io_space_enable           = pci_command[`BCC_CMD_IO];
  assign memory_space_enable       = pci_command[`BCC_CMD_MEM];
  assign request_forwarding_enable = pci_command[`BCC_CMD_FWD];
  assign poison_log_enable         = pci_command[`BCC_CMD_POISON];
  assign error_report_enable       = pci_command[`BCC_CMD_ERR];
  assign legacy_irq_disable        = pci_command[`BCC_CMD_IRQD];

  // request gating
  bcc_fwd_gate u_gate (
    .io_space_enable          (io_space_enable),
    .memory_space_enable      (memory_space_enable),
    .request_forwarding_enable(request_forwarding_enable),
    .pri_valid                (PRI_VALID),
    .pri_kind                 (PRI_KIND),
    .in_io_win                (PRI_IN_IO_WIN),
    .in_mem_win               (PRI_IN_MEM_WIN),
    .in_pmem_win              (PRI_IN_PMEM_WIN),
    .up_valid                 (UP_VALID),
    .up_kind                  (UP_KIND),
    .up_nonposted             (UP_NONPOSTED),
    .pri_claim                (PRI_CLAIM),
    .up_fwd                   (UP_FWD),
    .up_ur                    (UP_UR),
    .up_ur_cpl                (UP_UR_CPL)
  );

  // byte lane merge of write data
  always_comb begin
    wdata_cmd = pci_command;
    wdata_sts = 16'h0000;
    if (wr_be[0]) begin
      wdata_cmd[7:0] = CFG_WDATA[7:0];
    end
    if (wr_be[1]) begin
      wdata_cmd[15:8] = CFG_WDATA[15:8];
    end
    if (wr_be[2]) begin
      wdata_sts[7:0] = CFG_WDATA[23:16];
    end
    if (wr_be[3]) begin
      wdata_sts[15:8] = CFG_WDATA[31:24];
    end
  end

  // command and status flags
  always_comb begin
    next_pci_command = (pci_command & ~`BCC_CMD_WMASK) |
                       (wdata_cmd & `BCC_CMD_WMASK);
    poison_event = poison_log_enable &&
                   ((DN_CPL_VALID && DN_CPL_POISONED) ||
                    (UP_FWD && UP_KIND != KIND_CPL &&
                     UP_POISONED));
    next_master_poison_detected =
      poison_event ||
      (master_poison_detected && !wdata_sts[`BCC_STS_POISON]);
    next_sys_err = (error_report_enable && next_err_send) ||
                   (sys_err && !wdata_sts[`BCC_STS_SYSERR]);
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pci_command            <= `BCC_CMD_RESET;
      master_poison_detected <= 1'b0;
      sys_err                <= 1'b0;
    end else if (CE) begin
      pci_command            <= next_pci_command;
      master_poison_detected <= next_master_poison_detected;
      sys_err                <= next_sys_err;
    end
  end

  // read data
  always_comb begin
    next_rdata = CFG_RDATA;
    if (CFG_REQ && !CFG_ACK) begin
      if (hit_id) begin
        next_rdata = {DEVICE_ID, VENDOR_ID};
      end else if (hit_cmd) begin
        next_rdata = `BCC_ZERO32;
        next_rdata[`BCC_STS_POISON + 16] = master_poison_detected;
        next_rdata[`BCC_STS_SYSERR + 16] = sys_err;
        next_rdata[15:0] = pci_command;
      end else begin
        next_rdata = `BCC_ZERO32;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      CFG_RDATA <= `BCC_ZERO32;
    end else if (CE) begin
      CFG_RDATA <= next_rdata;
    end
  end

  // error messages and interrupts
  always_comb begin
    send_nf = OWN_ERR_NONFATAL && (error_report_enable || DEV_NONFATAL_EN);
    send_f  = OWN_ERR_FATAL && (error_report_enable || DEV_FATAL_EN);
    next_err_send  = send_nf || send_f;
    next_err_fatal = send_f;
    next_fwd = SEC_ERR_VALID &&
               (SEC_ERR_SEV == SEV_CORR || error_report_enable);
    next_fwd_sev = SEC_ERR_SEV;
    next_own_irq = OWN_IRQ && !legacy_irq_disable;
    next_fwd_irq = SEC_IRQ;
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ERR_MSG_SEND  <= 1'b0;
      ERR_MSG_FATAL <= 1'b0;
      PRI_ERR_FWD   <= 1'b0;
      PRI_ERR_SEV   <= SEV_CORR;
      OWN_IRQ_OUT   <= 1'b0;
      FWD_IRQ_OUT   <= 1'b0;
    end else if (CE) begin
      ERR_MSG_SEND  <= next_err_send;
      ERR_MSG_FATAL <= next_err_fatal;
      PRI_ERR_FWD   <= next_fwd;
      PRI_ERR_SEV   <= next_fwd_sev;
      OWN_IRQ_OUT   <= next_own_irq;
      FWD_IRQ_OUT   <= next_fwd_irq;
    end
  end

  assign COMMAND                = pci_command;
  assign MASTER_POISON_DETECTED = master_poison_detected;
  assign SIGNALED_SYSTEM_ERROR  = sys_err;

  // checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SRST);

  sequence s_cmd_write;
    CE && CFG_REQ && !CFG_ACK && CFG_WE && hit_cmd && CFG_BE[1:0] == 2'h3;
  endsequence

  property p_ro_zero;
    s_cmd_write |=> (pci_command & ~`BCC_CMD_WMASK) == 16'h0000;
  endproperty
  a_ro_zero: assert property (p_ro_zero)
    else $error("read-only command bits not zero");

  property p_cmd_store;
    s_cmd_write |=> pci_command ==
      ($past(CFG_WDATA[15:0]) & `BCC_CMD_WMASK);
  endproperty
  a_cmd_store: assert property (p_cmd_store)
    else $error("command write not stored");

  property p_cmd_reset;
    $fell(SRST) |-> pci_command == `BCC_CMD_RESET;
  endproperty
  a_cmd_reset: assert property (p_cmd_reset)
    else $error("command not cleared by reset");

  property p_id_read;
    CE && CFG_REQ && !CFG_ACK && hit_id
      |=> CFG_ACK && CFG_RDATA == {DEVICE_ID, VENDOR_ID};
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identity read wrong");

  property p_io_ignore;
    !io_space_enable && PRI_KIND == KIND_IO |-> !PRI_CLAIM;
  endproperty
  a_io_ignore: assert property (p_io_ignore)
    else $error("io request claimed while disabled");

  property p_mem_ignore;
    !memory_space_enable && PRI_KIND == KIND_MEM |-> !PRI_CLAIM;
  endproperty
  a_mem_ignore: assert property (p_mem_ignore)
    else $error("memory request claimed while disabled");

  property p_up_ur;
    UP_VALID && !request_forwarding_enable &&
      (UP_KIND == KIND_MEM || UP_KIND == KIND_IO || UP_KIND == KIND_MSI)
      |-> UP_UR && !UP_FWD && (UP_UR_CPL == UP_NONPOSTED);
  endproperty
  a_up_ur: assert property (p_up_ur)
    else $error("upstream request not refused");

  property p_cpl_pass;
    UP_VALID && (UP_KIND == KIND_CPL || UP_KIND == KIND_MSG)
      |-> UP_FWD && !UP_UR;
  endproperty
  a_cpl_pass: assert property (p_cpl_pass)
    else $error("completion or message blocked");

  sequence s_poison_in;
    CE && poison_log_enable && DN_CPL_VALID && DN_CPL_POISONED;
  endsequence

  property p_poison_set;
    s_poison_in |=> master_poison_detected;
  endproperty
  a_poison_set: assert property (p_poison_set)
    else $error("poison flag not set");

  property p_poison_hold;
    CE && !poison_log_enable && !master_poison_detected
      |=> !master_poison_detected;
  endproperty
  a_poison_hold: assert property (p_poison_hold)
    else $error("poison flag set while logging off");

  property p_err_fwd;
    CE && SEC_ERR_VALID |=>
      PRI_ERR_FWD == ($past(SEC_ERR_SEV) == SEV_CORR ||
                      $past(error_report_enable));
  endproperty
  a_err_fwd: assert property (p_err_fwd)
    else $error("error message forwarding wrong");

  property p_sys_err;
    CE && error_report_enable && (OWN_ERR_FATAL || OWN_ERR_NONFATAL)
      |=> ERR_MSG_SEND ##0 sys_err;
  endproperty
  a_sys_err: assert property (p_sys_err)
    else $error("system error flag or message missing");

  property p_irq;
    CE |=> OWN_IRQ_OUT == ($past(OWN_IRQ) && !$past(legacy_irq_disable))
       && FWD_IRQ_OUT == $past(SEC_IRQ);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output wrong");
endmodule
`default_nettype wire

// ==== verification/bcc_rc_model.sv ====
// root complex model: issues configuration reads and writes to the bridge
// assumes the bridge shares CLOCK and acks each request one edge after take
`timescale 1ns/1ps
`default_nettype none
module bcc_rc_model (
  // clock
  input  wire logic        CLOCK,
  // configuration requests
  output logic             CFG_REQ,
  output logic             CFG_WE,
  output logic [11:0]      CFG_ADDR,
  output logic [3:0]       CFG_BE,
  output logic [31:0]      CFG_WDATA,
  input  wire logic        CFG_ACK
);
  initial begin
    CFG_REQ   = 1'h0;
    CFG_WE    = 1'h0;
    CFG_ADDR  = 12'h000;
    CFG_BE    = 4'h0;
    CFG_WDATA = 32'h0000_0000;
  end

  // one transfer after gap + 1 idle edges; held until ack, released at that edge
  task automatic xfer(input logic we, input logic [11:0] addr,
                      input logic [3:0] be, input logic [31:0] data,
                      input int gap, output bit ok);
    int n;
    repeat (gap + 1) @(posedge CLOCK);
    CFG_REQ   <= 1'h1;
    CFG_WE    <= we;
    CFG_ADDR  <= addr;
    CFG_BE    <= be;
    CFG_WDATA <= data;
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge CLOCK);
      ok = CFG_ACK;
    end
    // released lines show the inverse of their last value
    CFG_REQ   <= 1'h0;
    CFG_WE    <= ~we;
    CFG_ADDR  <= ~addr;
    CFG_BE    <= ~be;
    CFG_WDATA <= ~data;
  endtask
endmodule
`default_nettype wire

// ==== verification/bridge_command_config_regs_test.sv ====
// testbench: reference model of the command registers compared each cycle
// assumes bcc_regs top and the root complex model on one 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module bridge_command_config_regs_test;
  import bcc_pkg::*;
  localparam logic [15:0] VEN = 16'hC3C3; // arbitrary value
  localparam logic [15:0] DEV = 16'h0F0F; // arbitrary value
  logic CLOCK, SRST, CE, CFG_REQ, CFG_WE, CFG_ACK;
  logic [11:0] CFG_ADDR;
  logic [3:0] CFG_BE;
  logic [31:0] CFG_WDATA, CFG_RDATA, m_rd;
  logic PRI_VALID, PRI_IN_IO_WIN, PRI_IN_MEM_WIN, PRI_IN_PMEM_WIN, PRI_CLAIM;
  logic UP_VALID, UP_NONPOSTED, UP_POISONED, UP_FWD, UP_UR, UP_UR_CPL;
  logic DN_CPL_VALID, DN_CPL_POISONED, SEC_ERR_VALID, PRI_ERR_FWD;
  logic OWN_ERR_NONFATAL, OWN_ERR_FATAL, DEV_NONFATAL_EN, DEV_FATAL_EN;
  logic ERR_MSG_SEND, ERR_MSG_FATAL, OWN_IRQ, SEC_IRQ, OWN_IRQ_OUT;
  logic FWD_IRQ_OUT, MASTER_POISON_DETECTED, SIGNALED_SYSTEM_ERROR;
  logic [15:0] COMMAND, m_cmd;
  bcc_kind_e PRI_KIND, UP_KIND;
  bcc_sev_e SEC_ERR_SEV, PRI_ERR_SEV, m_esev;
  logic m_pois, m_sse, m_ack, m_efwd, m_send, m_fatal, m_oirq, m_firq;
  logic tk, hc, nf, f, upf, cl, gated, armed;
  int fails, checks_done;
  bit ok;

  bcc_regs #(.VENDOR_ID(VEN), .DEVICE_ID(DEV)) u_bcc_regs (.*);
  bcc_rc_model u_bcc_rc_model (.CLOCK(CLOCK), .CFG_REQ(CFG_REQ),
    .CFG_WE(CFG_WE), .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE),
    .CFG_WDATA(CFG_WDATA), .CFG_ACK(CFG_ACK));

  initial begin
    CLOCK = 1'h0;
    forever #2.5 CLOCK = ~CLOCK;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cfg(input logic we, input logic [11:0] a,
                     input logic [3:0] be, input logic [31:0] d);
    u_bcc_rc_model.xfer(we, a, be, d, $urandom_range(3), ok);
    if (!ok) begin
      fails++;
      results();
    end
  endtask

  // reference model, updated at each taken edge
  always @(posedge CLOCK) if (CE) begin
    if (SRST) begin
      {m_cmd, m_pois, m_sse, m_ack, m_efwd, m_send, m_oirq, m_firq} = 0;
    end else begin
      tk = CFG_REQ && !m_ack;
      hc = CFG_ADDR[11:2] == 10'h001;
      if (tk)
        m_rd = CFG_ADDR[11:2] == 10'h000 ? {DEV, VEN} : hc ?
          {1'h0, m_sse, 5'h00, m_pois, 8'h00, m_cmd} : 32'h0000_0000;
      upf = UP_VALID && (m_cmd[2] || !(UP_KIND inside
        {KIND_MEM, KIND_IO, KIND_MSI}));
      nf = OWN_ERR_NONFATAL && (m_cmd[8] || DEV_NONFATAL_EN);
      f = OWN_ERR_FATAL && (m_cmd[8] || DEV_FATAL_EN);
      cl = tk && CFG_WE && hc && CFG_BE[3];
      m_pois = (m_cmd[6] && ((DN_CPL_VALID && DN_CPL_POISONED) || (upf
        && UP_POISONED && UP_KIND != KIND_CPL))) || (m_pois && !(cl &&
        CFG_WDATA[24]));
      m_sse = ((nf || f) && m_cmd[8]) ||
        (m_sse && !(cl && CFG_WDATA[30]));
      m_efwd = SEC_ERR_VALID && (SEC_ERR_SEV == SEV_CORR || m_cmd[8]);
      m_esev = SEC_ERR_SEV;
      m_send = nf || f;
      m_fatal = f;
      m_oirq = OWN_IRQ && !m_cmd[10];
      m_firq = SEC_IRQ;
      if (tk && CFG_WE && hc && CFG_BE[0])
        m_cmd[7:0] = CFG_WDATA[7:0] & 8'h47;
      if (tk && CFG_WE && hc && CFG_BE[1])
        m_cmd[15:8] = CFG_WDATA[15:8] & 8'h05;
      m_ack = tk;
    end
  end

  always @(negedge CLOCK) if (armed) begin
    gated = UP_VALID && !m_cmd[2] &&
      UP_KIND inside {KIND_MEM, KIND_IO, KIND_MSI};
    chk("PRI_CLAIM", PRI_VALID && ((PRI_KIND == KIND_IO && PRI_IN_IO_WIN
      && m_cmd[0]) || (PRI_KIND == KIND_MEM && (PRI_IN_MEM_WIN ||
      PRI_IN_PMEM_WIN) && m_cmd[1])), PRI_CLAIM);
    chk("UP_FWD", UP_VALID && !gated, UP_FWD);
    chk("UP_UR", gated, UP_UR);
    chk("UP_UR_CPL", gated && UP_NONPOSTED, UP_UR_CPL);
    chk("CFG_ACK", m_ack, CFG_ACK);
    if (m_ack) chk("CFG_RDATA", m_rd, CFG_RDATA);
    chk("COMMAND", m_cmd, COMMAND);
    chk("MASTER_POISON_DETECTED", m_pois, MASTER_POISON_DETECTED);
    chk("SIGNALED_SYSTEM_ERROR", m_sse, SIGNALED_SYSTEM_ERROR);
    chk("PRI_ERR_FWD", m_efwd, PRI_ERR_FWD);
    if (m_efwd) chk("PRI_ERR_SEV", m_esev, PRI_ERR_SEV);
    chk("ERR_MSG_SEND", m_send, ERR_MSG_SEND);
    if (m_send) chk("ERR_MSG_FATAL", m_fatal, ERR_MSG_FATAL);
    chk("OWN_IRQ_OUT", m_oirq, OWN_IRQ_OUT);
    chk("FWD_IRQ_OUT", m_firq, FWD_IRQ_OUT);
  end

  // random traffic on every side input, clock enable low one time in eight
  task automatic traffic(input int n);
    repeat (n) begin
      @(posedge CLOCK);
      CE <= $urandom_range(7) != 0;
      {PRI_VALID, PRI_IN_IO_WIN, PRI_IN_MEM_WIN, PRI_IN_PMEM_WIN, UP_VALID,
       UP_NONPOSTED, UP_POISONED, DN_CPL_VALID, DN_CPL_POISONED,
       SEC_ERR_VALID, OWN_ERR_NONFATAL, OWN_ERR_FATAL, DEV_NONFATAL_EN,
       DEV_FATAL_EN, OWN_IRQ, SEC_IRQ} <= 16'($urandom);
      PRI_KIND <= bcc_kind_e'($urandom_range(5));
      UP_KIND <= bcc_kind_e'($urandom_range(5));
      SEC_ERR_SEV <= bcc_sev_e'($urandom_range(2));
    end
    CE <= 1'h1;
  endtask

  initial begin
    fails = 0;
    checks_done = 0;
    armed = 1'h0;
    SRST = 1'h1;
    CE = 1'h1;
    {PRI_VALID, PRI_IN_IO_WIN, PRI_IN_MEM_WIN, PRI_IN_PMEM_WIN, UP_VALID,
     UP_NONPOSTED, UP_POISONED, DN_CPL_VALID, DN_CPL_POISONED,
     SEC_ERR_VALID, OWN_ERR_NONFATAL, OWN_ERR_FATAL, DEV_NONFATAL_EN,
     DEV_FATAL_EN, OWN_IRQ, SEC_IRQ} = 16'h0000;
    PRI_KIND = KIND_MEM;
    UP_KIND = KIND_MEM;
    SEC_ERR_SEV = SEV_CORR;
    void'($urandom(4));
    repeat (2) @(posedge CLOCK);
    armed = 1'h1;
    repeat (8) @(posedge CLOCK);
    SRST <= 1'h0;
    cfg(1'h0, 12'h000, 4'hF, 32'h0000_0000);
    cfg(1'h0, 12'h004, 4'hF, 32'h0000_0000);
    $display("test reset done");
    cfg(1'h1, 12'h004, 4'hF, 32'hFFFF_FFFF);
    cfg(1'h1, 12'h000, 4'hF, 32'h1234_5678);
    cfg(1'h1, 12'h008, 4'hF, 32'hFFFF_FFFF);
    repeat (40) cfg($urandom_range(1), $urandom_range(3) * 4,
      4'($urandom), $urandom);
    $display("test config done");
    fork
      traffic(3000);
      repeat (150) cfg($urandom_range(1), 12'h004, 4'($urandom),
        $urandom | 32'h4000_0000 * $urandom_range(1));
    join
    $display("test traffic done");
    cfg(1'h1, 12'h004, 4'h3, 32'h0000_0547);
    @(posedge CLOCK);
    SRST <= 1'h1;
    repeat (3) @(posedge CLOCK);
    SRST <= 1'h0;
    cfg(1'h0, 12'h004, 4'hF, 32'h0000_0000);
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
